// [hdl/prc_pkg.sv]
package prc_pkg;

  // ------------------------------------------------------------------
  // register offsets on the control port
  // ------------------------------------------------------------------
  localparam logic [7:0] PRC_ADDR_DEV_CTRL   = 8'h02;
  localparam logic [7:0] PRC_ADDR_CFG_FIRST  = 8'h03;
  localparam logic [7:0] PRC_ADDR_CFG_SECOND = 8'h04;
  localparam logic [7:0] PRC_ADDR_GLOBAL     = 8'h05;
  localparam logic [7:0] PRC_ADDR_RATIO_BASE = 8'h06;
  localparam logic [7:0] PRC_ADDR_RATIO_LAST = 8'h15;
  localparam logic [7:0] PRC_ADDR_FUNC_FIRST = 8'h16;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  // device control
  localparam int PRC_CTRL_UNLOCK_BIT   = 7;
  localparam int PRC_CTRL_RATE_LSB     = 5;
  localparam int PRC_CTRL_AUX_DIS_BIT  = 1;
  localparam int PRC_CTRL_CLK_DIS_BIT  = 0;
  // device config first
  localparam int PRC_CFG1_SHIFT_LSB    = 5;
  localparam int PRC_CFG1_STATIC_LSB   = 3;
  localparam int PRC_CFG1_AUX_SRC_LSB  = 1;
  localparam int PRC_CFG1_UNLOCK_BIT   = 0;
  // device config second
  localparam int PRC_CFG2_AUTO_MOD_BIT = 3;
  localparam int PRC_CFG2_HYBRID_LSB   = 1;
  localparam int PRC_CFG2_FRAC_SRC_BIT = 0;
  // global config
  localparam int PRC_GLB_FREEZE_BIT    = 3;
  localparam int PRC_GLB_UNLOCK_BIT    = 0;
  // function config first
  localparam int PRC_FN1_SKIP_BIT      = 7;
  localparam int PRC_FN1_LOCK_CFG_BIT  = 6;
  localparam int PRC_FN1_REFDIV_LSB    = 3;

  // writable masks; reserved bits stay zero
  localparam logic [7:0] PRC_MASK_DEV_CTRL   = 8'h03;
  localparam logic [7:0] PRC_MASK_CFG_SECOND = 8'h0F;
  localparam logic [7:0] PRC_MASK_GLOBAL     = 8'h09;
  localparam logic [7:0] PRC_MASK_FUNC_FIRST = 8'hD8;

  // reset value of every configuration byte
  localparam logic [7:0] PRC_RESET_BYTE = 8'h00;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam int          PRC_RATIO_COUNT = 4;
  localparam int          PRC_RATIO_BYTES = 16;
  localparam logic [1:0]  PRC_AUX_REF     = 2'b00;
  localparam logic [1:0]  PRC_AUX_CLKIN   = 2'b01;
  localparam logic [1:0]  PRC_AUX_PLLOUT  = 2'b10;
  localparam logic [1:0]  PRC_AUX_LOCK    = 2'b11;

  // picks one 32-bit ratio out of the packed set, word k at [32k+:32]
  function automatic logic [31:0] prc_pick(input logic [127:0] words,
                                            input logic [1:0]   sel);
    prc_pick = words[{sel, 5'b00000} +: 32];
  endfunction

endpackage

// [hdl/prc_ratio_if.sv]
`timescale 1ns/1ns
`default_nettype none

// ratio words and selectors handed to the ratio datapath
interface prc_ratio_if;
  logic [127:0] words;       // four ratios, word k at [32k+:32]
  logic [1:0]   static_sel;  // static mode ratio index
  logic [1:0]   hybrid_sel;  // hybrid mode ratio index
  logic [2:0]   shift_sel;   // ratio shift code
  logic [31:0]  eff_ratio;   // shifted static ratio
  logic [31:0]  hyb_ratio;   // selected hybrid ratio

  modport cfg  (output words, static_sel, hybrid_sel, shift_sel,
                input  eff_ratio, hyb_ratio);
  modport path (input  words, static_sel, hybrid_sel, shift_sel,
                output eff_ratio, hyb_ratio);
endinterface

`default_nettype wire

// [hdl/prc_ratio_path.sv]
`timescale 1ns/1ns
`default_nettype none

module prc_ratio_path
  import prc_pkg::*;
(
  input  wire logic   clk,  // system clock
  input  wire logic   rst,  // async reset, high
  prc_ratio_if.path   rp    // ratio words in, ratios out
);

  // ------------------------------------------------------------------
  // selection and scaling
  // ------------------------------------------------------------------
  logic [31:0] static_word;
  logic [31:0] hybrid_word;
  logic [2:0]  right_amt;
  logic [31:0] scaled_word;
  logic [31:0] eff_q;
  logic [31:0] hyb_q;

  assign static_word = prc_pick(rp.words, rp.static_sel);
  assign hybrid_word = prc_pick(rp.words, rp.hybrid_sel);

  assign right_amt   = {1'b0, rp.shift_sel[1:0]} + 3'd1;
  assign scaled_word = rp.shift_sel[2] ? (static_word >> right_amt)
                                       : (static_word << rp.shift_sel[1:0]);

  // registered so the ratio outputs never glitch on a selector change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_q <= 32'h00000000;
      hyb_q <= 32'h00000000;
    end else begin
      eff_q <= scaled_word;
      hyb_q <= hybrid_word;
    end
  end

  assign rp.eff_ratio = eff_q;
  assign rp.hyb_ratio = hyb_q;

endmodule

`default_nettype wire

// [hdl/prc_regs.sv]
`timescale 1ns/1ns
`default_nettype none

module prc_regs
  import prc_pkg::*;
(
  input  wire logic        clk,                         // system clock, 20 MHz
  input  wire logic        rst,                         // async reset, high
  // register port from the serial front end
  input  wire logic        reg_wr,                      // write strobe, one cycle
  input  wire logic        reg_rd,                      // read strobe, one cycle
  input  wire logic [7:0]  reg_addr,                    // register offset
  input  wire logic [7:0]  reg_wdata,                   // write byte
  input  wire logic        i2c_mode,                    // 1 i2c, 0 spi
  output logic      [7:0]  reg_rdata,                   // read byte
  output logic             reg_rvalid,                  // read data valid pulse
  // status from the pll
  input  wire logic        pll_locked,                  // pll lock level
  input  wire logic [1:0]  rate_detect,                 // input rate range code
  // clock sources for the aux pin, sampled as data
  input  wire logic        timing_reference_clock,      // reference clock
  input  wire logic        clk_in_sample,               // input clock
  input  wire logic        pll_clk_sample,              // pll output clock
  // configuration to the pll
  output logic [31:0]      effective_ratio,             // scaled static ratio
  output logic [31:0]      hybrid_ratio,                // hybrid mode ratio
  output logic             fractional_source_sel,       // 0 static, 1 hybrid
  output logic             auto_ratio_modifier_en,      // auto modifier on
  output logic             missing_pulse_tolerance_en,  // clock skip on
  output logic [1:0]       ref_divider_sel,             // reference divider code
  output logic             control_port_en,             // control port mode
  output logic             clk_out_disable,             // clock output off
  // aux pin
  output logic             aux_out,                     // aux pin level
  output logic             aux_oe                       // aux pin drive enable
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic hit_ctrl;
  logic hit_cfg1;
  logic hit_cfg2;
  logic hit_glb;
  logic hit_fn1;
  logic hit_ratio;
  logic [7:0] ratio_idx;

  // one compare per register, one range check for the ratio bytes; anything else decodes to nothing
  assign hit_ctrl  = reg_addr == PRC_ADDR_DEV_CTRL;
  assign hit_cfg1  = reg_addr == PRC_ADDR_CFG_FIRST;
  assign hit_cfg2  = reg_addr == PRC_ADDR_CFG_SECOND;
  assign hit_glb   = reg_addr == PRC_ADDR_GLOBAL;
  assign hit_fn1   = reg_addr == PRC_ADDR_FUNC_FIRST;
  assign hit_ratio = (reg_addr >= PRC_ADDR_RATIO_BASE) &&
                     (reg_addr <= PRC_ADDR_RATIO_LAST);
  assign ratio_idx = reg_addr - PRC_ADDR_RATIO_BASE;

  // ------------------------------------------------------------------
  // per-register strobes
  // ------------------------------------------------------------------
  logic        wr_ctrl;
  logic        wr_cfg1;
  logic        wr_cfg2;
  logic        wr_glb;
  logic        wr_fn1;
  logic        rd_take;
  logic [15:0] wr_ratio;

  // one decoded strobe per register keeps the next-value muxes flat
  assign wr_ctrl = reg_wr && hit_ctrl;
  assign wr_cfg1 = reg_wr && hit_cfg1;
  assign wr_cfg2 = reg_wr && hit_cfg2;
  assign wr_glb  = reg_wr && hit_glb;
  assign wr_fn1  = reg_wr && hit_fn1;
  // spi reads refused
  // a spi host cannot read, so its strobe is dropped before the data flops
  assign rd_take = reg_rd && i2c_mode;

  // ratio byte enables; an offset outside 06h..15h enables none
  for (genvar ge = 0; ge < PRC_RATIO_BYTES; ge++) begin : g_ratio_we
    assign wr_ratio[ge] = hit_ratio && reg_wr && (ratio_idx == 8'(ge));
  end

  // ------------------------------------------------------------------
  // written (staged) registers
  // ------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] glb_q;
  logic [7:0] fn1_q;
  logic [7:0] ctrl_d;
  logic [7:0] cfg1_d;
  logic [7:0] cfg2_d;
  logic [7:0] glb_d;
  logic [7:0] fn1_d;

  // next values; reserved bits are masked so they stay at their default
  assign ctrl_d = wr_ctrl ? (reg_wdata & PRC_MASK_DEV_CTRL)   : ctrl_q;
  assign cfg1_d = wr_cfg1 ? reg_wdata                         : cfg1_q;
  assign cfg2_d = wr_cfg2 ? (reg_wdata & PRC_MASK_CFG_SECOND) : cfg2_q;
  assign glb_d  = wr_glb  ? (reg_wdata & PRC_MASK_GLOBAL)     : glb_q;
  assign fn1_d  = wr_fn1  ? (reg_wdata & PRC_MASK_FUNC_FIRST) : fn1_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= PRC_RESET_BYTE;
      cfg1_q <= PRC_RESET_BYTE;
      cfg2_q <= PRC_RESET_BYTE;
      glb_q  <= PRC_RESET_BYTE;
      fn1_q  <= PRC_RESET_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      glb_q  <= glb_d;
      fn1_q  <= fn1_d;
    end
  end

  // ------------------------------------------------------------------
  // live copies of 02h..04h behind the freeze
  // ------------------------------------------------------------------
  logic       freeze;
  logic [7:0] ctrl_live_q;
  logic [7:0] cfg1_live_q;
  logic [7:0] cfg2_live_q;
  logic [7:0] ctrl_live_d;
  logic [7:0] cfg1_live_d;
  logic [7:0] cfg2_live_d;

  // freeze itself is never held back, so clearing it always works
  assign freeze = glb_q[PRC_GLB_FREEZE_BIT];

  // unfrozen follows
  // the live copy trails the staged one by a cycle, so a burst of writes
  // released by clearing freeze lands on the pll all at once
  assign ctrl_live_d = freeze ? ctrl_live_q : ctrl_q;
  assign cfg1_live_d = freeze ? cfg1_live_q : cfg1_q;
  assign cfg2_live_d = freeze ? cfg2_live_q : cfg2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_live_q <= PRC_RESET_BYTE;
      cfg1_live_q <= PRC_RESET_BYTE;
      cfg2_live_q <= PRC_RESET_BYTE;
    end else begin
      ctrl_live_q <= ctrl_live_d;
      cfg1_live_q <= cfg1_live_d;
      cfg2_live_q <= cfg2_live_d;
    end
  end

  // ------------------------------------------------------------------
  // user ratio bytes
  // ------------------------------------------------------------------
  logic [7:0]   ratio_byte_q [PRC_RATIO_BYTES];
  logic [127:0] ratio_words;

  for (genvar gb = 0; gb < PRC_RATIO_BYTES; gb++) begin : g_ratio_byte
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ratio_byte_q[gb] <= PRC_RESET_BYTE;
      end else if (wr_ratio[gb]) begin
        ratio_byte_q[gb] <= reg_wdata;
      end
    end
  end

  for (genvar gw = 0; gw < PRC_RATIO_COUNT; gw++) begin : g_ratio_word
    assign ratio_words[32*gw +: 32] = {ratio_byte_q[4*gw],
                                       ratio_byte_q[4*gw+1],
                                       ratio_byte_q[4*gw+2],
                                       ratio_byte_q[4*gw+3]};
  end

  // ------------------------------------------------------------------
  // ratio datapath
  // ------------------------------------------------------------------
  prc_ratio_if rif ();

  // selectors come from the live copy so freeze covers them too
  assign rif.words      = ratio_words;
  assign rif.static_sel = cfg1_live_q[PRC_CFG1_STATIC_LSB +: 2];
  assign rif.hybrid_sel = cfg2_live_q[PRC_CFG2_HYBRID_LSB +: 2];
  assign rif.shift_sel  = cfg1_live_q[PRC_CFG1_SHIFT_LSB +: 3];

  // ratio bytes bypass freeze; only the selectors are held back
  prc_ratio_path u_path (
    .clk (clk),
    .rst (rst),
    .rp  (rif.path)
  );

  assign effective_ratio = rif.eff_ratio;
  assign hybrid_ratio    = rif.hyb_ratio;

  // ------------------------------------------------------------------
  // mode and control outputs
  // ------------------------------------------------------------------
  // fractional source
  assign fractional_source_sel      = cfg2_live_q[PRC_CFG2_FRAC_SRC_BIT];
  assign auto_ratio_modifier_en     = cfg2_live_q[PRC_CFG2_AUTO_MOD_BIT];
  // clock skip
  // the below-80 kHz input limit is the host's to respect; nothing checks it
  assign missing_pulse_tolerance_en = fn1_q[PRC_FN1_SKIP_BIT];
  assign ref_divider_sel            = fn1_q[PRC_FN1_REFDIV_LSB +: 2];
  assign clk_out_disable            = ctrl_live_q[PRC_CTRL_CLK_DIS_BIT];

  assign control_port_en = cfg1_live_q[PRC_CFG1_UNLOCK_BIT] &
                           glb_q[PRC_GLB_UNLOCK_BIT];

  // ------------------------------------------------------------------
  // aux pin
  // ------------------------------------------------------------------
  logic [1:0] aux_src;
  logic       lock_cfg;
  logic       aux_dis;
  logic       clk_pick;
  logic       aux_d;
  logic       oe_d;
  logic       aux_q;
  logic       oe_q;

  assign aux_src  = cfg1_live_q[PRC_CFG1_AUX_SRC_LSB +: 2];
  assign lock_cfg = fn1_q[PRC_FN1_LOCK_CFG_BIT];
  assign aux_dis  = ctrl_live_q[PRC_CTRL_AUX_DIS_BIT];

  always_comb begin
    case (aux_src)
      PRC_AUX_REF:    clk_pick = timing_reference_clock;
      PRC_AUX_CLKIN:  clk_pick = clk_in_sample;
      PRC_AUX_PLLOUT: clk_pick = pll_clk_sample;
      default:        clk_pick = 1'b0;
    endcase
  end

  // pin level and enable; the disable bit wins over every source
  always_comb begin
    aux_d = clk_pick;
    oe_d  = 1'b1;
    if (aux_src == PRC_AUX_LOCK) begin
      if (lock_cfg) begin
        aux_d = 1'b0;
        oe_d  = ~pll_locked;
      end else begin
        aux_d = ~pll_locked;
        oe_d  = 1'b1;
      end
    end
    if (aux_dis) begin
      oe_d = 1'b0;
    end
  end

  // a clock routed here is resampled at 20 MHz, so only slow clocks pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      aux_q <= aux_d;
      oe_q  <= oe_d;
    end
  end

  assign aux_out = aux_q;
  assign aux_oe  = oe_q;

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  // status bits show the pll state, the rest echo what was written
  assign ctrl_view = {~pll_locked, rate_detect, ctrl_q[4:0]};

  // unmapped offsets and reserved bits read back as zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit_ctrl) begin
      rd_mux = ctrl_view;
    end else if (hit_cfg1) begin
      rd_mux = cfg1_q;
    end else if (hit_cfg2) begin
      rd_mux = cfg2_q;
    end else if (hit_glb) begin
      rd_mux = glb_q;
    end else if (hit_fn1) begin
      rd_mux = fn1_q;
    end else if (hit_ratio) begin
      rd_mux = ratio_byte_q[ratio_idx[3:0]];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rd_take ? rd_mux : 8'h00;
      rvalid_q <= rd_take;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

endmodule

`default_nettype wire

// [tb/prc_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module prc_regs_checker
  import prc_pkg::*;
(
  input wire logic        clk,                         // system clock
  input wire logic        rst,                         // async reset
  input wire logic        reg_wr,                      // write strobe
  input wire logic        reg_rd,                      // read strobe
  input wire logic [7:0]  reg_addr,                    // offset
  input wire logic [7:0]  reg_wdata,                   // write byte
  input wire logic        i2c_mode,                    // 1 readable
  input wire logic [7:0]  reg_rdata,                   // read byte
  input wire logic        reg_rvalid,                  // read valid
  input wire logic [31:0] effective_ratio,             // static ratio
  input wire logic [31:0] hybrid_ratio,                // hybrid ratio
  input wire logic        fractional_source_sel,       // ratio source
  input wire logic        auto_ratio_modifier_en,      // auto modifier
  input wire logic        missing_pulse_tolerance_en,  // clock skip
  input wire logic [1:0]  ref_divider_sel,             // ref divider
  input wire logic        control_port_en              // control mode
);
  logic frz_q;  // freeze bit as last written

  // freeze acts at once, so a shadow of the last write is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frz_q <= 1'b0;
    end else if (reg_wr && reg_addr == PRC_ADDR_GLOBAL) begin
      frz_q <= reg_wdata[PRC_GLB_FREEZE_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // a config write with nothing overwriting it one cycle later
  sequence s_cfg2_open;
    reg_wr && reg_addr == PRC_ADDR_CFG_SECOND && !frz_q
      ##1 !(reg_wr && reg_addr inside {[PRC_ADDR_DEV_CTRL:PRC_ADDR_GLOBAL]});
  endsequence
  sequence s_unlock_off;
    reg_wr && reg_addr == PRC_ADDR_GLOBAL && !reg_wdata[PRC_GLB_UNLOCK_BIT]
      ##1 !(reg_wr && reg_addr == PRC_ADDR_GLOBAL);
  endsequence

  property p_rd_answer;
    reg_rd && i2c_mode |=> reg_rvalid;
  endproperty
  property p_rd_spi;
    reg_rd && !i2c_mode |=> !reg_rvalid && reg_rdata == 8'h00;
  endproperty
  property p_rd_idle;
    !$past(reg_rd && i2c_mode) |-> reg_rdata == 8'h00 && !reg_rvalid;
  endproperty
  property p_reset_zero;
    $past(rst) |-> effective_ratio == 32'h0 && hybrid_ratio == 32'h0
      && !fractional_source_sel && !control_port_en && !missing_pulse_tolerance_en;
  endproperty
  property p_unlock;
    s_unlock_off |=> !control_port_en;
  endproperty
  property p_skip;
    reg_wr && reg_addr == PRC_ADDR_FUNC_FIRST |=> missing_pulse_tolerance_en
      == $past(reg_wdata[7]) && ref_divider_sel == $past(reg_wdata[4:3]);
  endproperty
  property p_cfg2_live;
    s_cfg2_open |=> fractional_source_sel == $past(reg_wdata[0], 2)
      && auto_ratio_modifier_en == $past(reg_wdata[3], 2);
  endproperty
  property p_frozen;
    frz_q && $past(frz_q) |-> $stable(fractional_source_sel) && $stable(auto_ratio_modifier_en);
  endproperty

  a_rd_answer:  assert property (p_rd_answer)  else $error("read not answered");
  a_rd_spi:     assert property (p_rd_spi)     else $error("spi read answered");
  a_rd_idle:    assert property (p_rd_idle)    else $error("read bus not idle");
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");
  a_unlock:     assert property (p_unlock)     else $error("port mode stays on");
  a_skip:       assert property (p_skip)       else $error("skip bits wrong");
  a_cfg2_live:  assert property (p_cfg2_live)  else $error("config not applied");
  a_frozen:     assert property (p_frozen)     else $error("frozen value moved");
endmodule

`default_nettype wire

// [tb/prc_host.sv]
`timescale 1ns/1ns
`default_nettype none

module prc_host (
  input  wire logic       clk,         // system clock
  output var  logic       reg_wr,      // write strobe
  output var  logic       reg_rd,      // read strobe
  output var  logic [7:0] reg_addr,    // offset
  output var  logic [7:0] reg_wdata,   // write byte
  input  wire logic [7:0] reg_rdata,   // read byte
  input  wire logic       reg_rvalid   // read valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one strobe per byte; released lines show the inverse so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask

  task automatic init();
    wr(8'h03, 8'h01);
    wr(8'h05, 8'h01);
  endtask
endmodule

`default_nettype wire

// [tb/pll_ratio_config_registers_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module pll_ratio_config_registers_bench
  import prc_pkg::*;
;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] rb;} prc_row_t;
  typedef struct {logic [1:0] src; logic cfg; logic lk; logic o; logic oe;} prc_aux_t;
  logic clk, rst, i2c_mode, pll_locked, ref_s, clkin_s, pllclk_s;
  logic reg_wr, reg_rd, reg_rvalid, frac, auto_en, skip, cpe, cod, aux_out, aux_oe;
  logic [1:0] rate_detect, refdiv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic [31:0] eff, hyb, w;
  logic v;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  prc_row_t rows [8] = '{'{8'h02, 8'hFF, 8'h43}, '{8'h03, 8'hAA, 8'hAA},
    '{8'h04, 8'hFF, 8'h0F}, '{8'h09, 8'h5A, 8'h5A}, '{8'h16, 8'hFF, 8'hD8},
    '{8'h17, 8'hFF, 8'h00}, '{8'h00, 8'hFF, 8'h00}, '{8'h05, 8'hFF, 8'h09}};
  prc_aux_t auxr [7] = '{'{2'b00, 1'b0, 1'b1, 1'b1, 1'b1}, '{2'b01, 1'b1, 1'b1, 1'b0, 1'b1},
    '{2'b10, 1'b1, 1'b0, 1'b1, 1'b1}, '{2'b11, 1'b0, 1'b1, 1'b0, 1'b1},
    '{2'b11, 1'b0, 1'b0, 1'b1, 1'b1}, '{2'b11, 1'b1, 1'b0, 1'b0, 1'b1},
    '{2'b11, 1'b1, 1'b1, 1'b0, 1'b0}};

  prc_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  prc_regs dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .i2c_mode(i2c_mode), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pll_locked(pll_locked), .rate_detect(rate_detect),
    .timing_reference_clock(ref_s), .clk_in_sample(clkin_s), .pll_clk_sample(pllclk_s),
    .effective_ratio(eff), .hybrid_ratio(hyb), .fractional_source_sel(frac),
    .auto_ratio_modifier_en(auto_en), .missing_pulse_tolerance_en(skip),
    .ref_divider_sel(refdiv), .control_port_en(cpe), .clk_out_disable(cod),
    .aux_out(aux_out), .aux_oe(aux_oe));

  function automatic logic [31:0] wk(input int k);
    return 32'h9A3C_5E71 + 32'(k) * 32'h0101_0101;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // live copies land two cycles after the write, ratio and aux pin outputs one more
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {i2c_mode, pll_locked, ref_s, clkin_s, pllclk_s} = 5'b11101;
    rate_detect = 2'b10;
    do_reset();
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, b, v);
      chk("readback", {v, b}, {1'b1, rows[i].rb});
    end
    chk("clk_out_disable", cod, 1);
    chk("aux pin disabled", aux_oe, 0);
    do_reset();
    foreach (rows[i]) begin
      host.rd(rows[i].a, b, v);
      chk("reset byte", b, (rows[i].a == 8'h02) ? 8'h40 : 8'h00);
    end
    chk("reset flags", {cpe, frac, auto_en, skip, refdiv, cod}, 0);
    chk("reset static ratio", eff, 0);
    chk("reset hybrid ratio", hyb, 0);
    host.init();
    settle();
    chk("port mode on", cpe, 1);
    host.wr(8'h05, 8'h00);
    settle();
    chk("port mode off", cpe, 0);
    host.wr(8'h05, 8'h01);
    for (int k = 0; k < 4; k++) begin
      w = wk(k);
      for (int j = 0; j < 4; j++) host.wr(PRC_ADDR_RATIO_BASE + 8'(4 * k + j), w[31 - 8 * j -: 8]);
    end
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h04, 8'(k << 1));
      settle();
      chk("hybrid ratio", hyb, wk(k));
    end
    for (int s = 0; s < 8; s++) begin
      host.wr(8'h03, {3'(s), 2'(s), 3'b001});
      settle();
      chk("effective ratio", eff, s < 4 ? wk(s % 4) << s : wk(s % 4) >> (s - 3));
    end
    host.wr(8'h05, 8'h09);
    host.wr(8'h04, 8'h09);
    settle();
    chk("frozen source", {auto_en, frac}, 0);
    host.rd(8'h04, b, v);
    chk("staged byte", b, 8'h09);
    host.wr(8'h05, 8'h01);
    settle();
    chk("released source", {auto_en, frac}, 2'b11);
    host.wr(8'h04, 8'h00);
    settle();
    chk("static source", {auto_en, frac}, 0);
    foreach (auxr[i]) begin
      pll_locked = auxr[i].lk;
      host.wr(8'h16, {1'b0, auxr[i].cfg, 6'h00});
      host.wr(8'h03, {5'h00, auxr[i].src, 1'b1});
      settle();
      chk("aux pin", {aux_out, aux_oe}, {auxr[i].o, auxr[i].oe});
    end
    pll_locked = 1'b1;
    // host keeps skipping for slow input clocks only
    host.wr(8'h16, 8'h90);
    settle();
    chk("skip and divider", {skip, refdiv}, 3'b110);
    i2c_mode = 1'b0;
    host.rd(8'h03, b, v);
    chk("spi read", {v, b}, 0);
    i2c_mode = 1'b1;
    summarize();
  end
endmodule

bind prc_regs prc_regs_checker chk_i (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .i2c_mode(i2c_mode),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .effective_ratio(effective_ratio),
  .hybrid_ratio(hybrid_ratio), .fractional_source_sel(fractional_source_sel),
  .auto_ratio_modifier_en(auto_ratio_modifier_en),
  .missing_pulse_tolerance_en(missing_pulse_tolerance_en),
  .ref_divider_sel(ref_divider_sel), .control_port_en(control_port_en));

`default_nettype wire
